// [core/nvm_ctrl_pkg.sv]
// package: constants for the nonvolatile store control block
// assumes a single 100 MHz system clock and an external register access port
package nvm_ctrl_pkg;
  localparam logic [7:0] ctrl_addr = 8'hff; // control register location
  localparam int bit_start = 7; // store-start bit
  localparam int bit_lock_req = 6; // lock-request bit
  localparam int bit_lock_stat = 5; // lock-status bit
  localparam logic [7:0] ctrl_reset = 8'h00; // all fields zero after reset
  localparam int cfg_width_dflt = 16; // selected config bits to store
  localparam int cycles_per_bit = 4; // program cycles per stored bit
endpackage : nvm_ctrl_pkg

// [core/nvm_cell_array.sv]
// nonvolatile cell array model: one bit per selected config bit plus lock request
// assumes writes are only presented by the store sequencer
`timescale 1ns/10ps
`default_nettype none
module nvm_cell_array #(
  parameter int width = 17 // stored bits
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, active high
  input wire logic wr_en, // write one bit this cycle
  input wire logic [$clog2(width)-1:0] wr_idx, // bit index to write
  input wire logic wr_bit, // bit value
  output logic [width-1:0] rd_data // stored contents, registered
);
  logic [width-1:0] cells_q; // one register per stored bit

  // the index port cannot address fewer than two cells
  if (width < 2) begin : g_width_bad
    $error("width too small");
  end

  // cells keep a plain default after reset; a real array would hold across power
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cells_q <= '0;
    end else if (wr_en) begin
      cells_q[wr_idx] <= wr_bit;
    end
  end
  assign rd_data = cells_q;
endmodule : nvm_cell_array
`default_nettype wire

// [core/nvm_store_lock_control.sv]
// nonvolatile store and lock control with its control register
// assumes the serial register interface delivers one-cycle write/read strobes
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1: writing one to start copies selected bits
// R2: start bit clears itself after last bit
// R3: lock request plus store locks permanently
// R4: once locked, further stores are rejected
// R5: lock status reads one when locked
// R6: low five bits ignore writes, read zero
// R7: lock request stored; start, status from logic
module nvm_store_lock_control #(
  parameter int cfg_width = nvm_ctrl_pkg::cfg_width_dflt // config bits to store
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, active high
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic [cfg_width-1:0] cfg_bits, // live selected config bits
  output logic [7:0] reg_rdata, // read data, registered
  output logic [cfg_width-1:0] cfg_default, // stored defaults, registered
  output logic store_busy // store in progress, registered
);
  import nvm_ctrl_pkg::*;
  // derived sizes: the lock request rides along as the last stored bit
  localparam int nbits = cfg_width + 1; // config bits plus lock request
  localparam int iw = $clog2(nbits); // width of the bit walker index
  localparam logic [iw-1:0] last_idx = iw'(nbits - 1); // index of the lock request bit
  localparam logic [2:0] pace_last = 3'(cycles_per_bit - 1); // last pacing step of a bit
  // a whole store: every bit paced, then one finishing cycle
  localparam int store_cycles = nbits * cycles_per_bit + 1;

  // elaboration checks: the pacing counter has three bits, and a longer
  // store would outgrow the plain delay of the length check below
  if (cfg_width < 1 || cfg_width > 64) begin : g_width_bad
    $error("cfg_width out of range");
  end
  if (cycles_per_bit < 1 || cycles_per_bit > 8) begin : g_pace_bad
    $error("cycles_per_bit out of range");
  end

  // one-hot sequencer states
  typedef enum logic [2:0] {
    st_idle = 3'b001, // waiting
    st_prog = 3'b010, // programming bits
    st_done = 3'b100 // finishing
  } state_t;

  state_t state_q, state_d; // sequencer state
  logic start_q; // store-start bit
  logic lock_req_q; // lock-request register value
  logic locked_q; // permanent lock
  logic [iw-1:0] idx_q; // current bit index
  logic [2:0] pace_q; // program pacing
  logic [cfg_width:0] snap_q; // captured bits to store
  logic [7:0] rdata_q; // read data register
  logic [cfg_width-1:0] default_q; // defaults as seen by the converter
  logic busy_q; // store in progress flag
  logic [nbits-1:0] cells; // array contents

  // decode: only the control register is mapped; other addresses read zero
  wire ctrl_hit = (reg_addr == ctrl_addr);
  wire wr_ctrl = reg_wr && ctrl_hit;
  // a start is only seen while idle; a start written during a store is dropped
  wire start_req = wr_ctrl && reg_wdata[bit_start] && (state_q == st_idle); // see R1
  wire start_ok = start_req && !locked_q; // see R4
  // one bit is committed on the last pacing step of that bit
  wire bit_done = (state_q == st_prog) && (pace_q == pace_last);
  wire last_bit = bit_done && (idx_q == last_idx);
  wire cell_wr = bit_done;
  // read view: status comes from logic, reserved bits are forced to zero
  wire [7:0] ctrl_view = {start_q, lock_req_q, locked_q, 5'b0_0000}; // see R6, R5
  wire [7:0] rd_mux = ctrl_hit ? ctrl_view : 8'h00;

  // sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_idle: begin
        if (start_ok) state_d = st_prog; // accepted start
      end
      st_prog: begin
        if (last_bit) state_d = st_done; // lock request bit written last
      end
      st_done: state_d = st_idle; // one finishing cycle
      default: state_d = st_idle;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) state_q <= st_idle;
    else state_q <= state_d;
  end

  // start bit: set by a one write, cleared by hardware after last bit
  // a rejected start (locked) never sets it, so nothing appears pending
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) start_q <= 1'b0;
    else if (start_ok) start_q <= 1'b1; // see R1
    else if (state_q == st_done) start_q <= 1'b0; // see R2
  end

  // lock request writable only while unlocked; kept in cells across power
  // a write during a store leaves it alone, so the snapshot stays meaningful
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) lock_req_q <= 1'b0;
    else if (wr_ctrl && !locked_q && state_q == st_idle) lock_req_q <= reg_wdata[bit_lock_req];
  end

  // lock is sticky; only reset of the model clears it (power cycle re-reads cells)
  // it takes effect at the end of the store that carried the request
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) locked_q <= 1'b0;
    else if (state_q == st_done && snap_q[cfg_width]) locked_q <= 1'b1; // see R3
  end

  // snapshot and bit walker
  // the request bit is taken from the write itself: a start written together
  // with a lock request must store and apply that same request
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      snap_q <= '0;
      idx_q <= '0;
      pace_q <= '0;
    end else if (start_ok) begin
      snap_q <= {reg_wdata[bit_lock_req], cfg_bits}; // see R7, R3
      idx_q <= '0;
      pace_q <= '0;
    end else if (state_q == st_prog) begin
      pace_q <= bit_done ? 3'b000 : pace_q + 3'b001;
      if (bit_done && !last_bit) idx_q <= idx_q + iw'(1);
    end
  end

  // cell array: one bit written per paced bit, on its last pacing step
  nvm_cell_array #(.width(nbits)) u_cells (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(cell_wr),
    .wr_idx(idx_q),
    .wr_bit(snap_q[idx_q]),
    .rd_data(cells)
  );

  // registered outputs; defaults trail the cells by one cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= ctrl_reset;
      default_q <= '0;
      busy_q <= 1'b0;
    end else begin
      if (reg_rd) rdata_q <= rd_mux; // read data holds until the next read
      default_q <= cells[cfg_width-1:0];
      busy_q <= (state_d != st_idle); // rises at the edge that takes the write
    end
  end
  assign reg_rdata = rdata_q;
  assign cfg_default = default_q;
  assign store_busy = busy_q;

  // assertions
  // the finishing cycle always clears the start bit
  a_start_clears: assert property (@(posedge clk_sys) disable iff (rst) // see R2
    (state_q == st_done) |=> !start_q)
    else $error("start bit not cleared");

  // a locked store never leaves idle again
  a_locked_rejects: assert property (@(posedge clk_sys) disable iff (rst) // see R4
    (locked_q && state_q == st_idle) |=> state_q == st_idle)
    else $error("store while locked");

  // the lock can never be undone
  a_lock_sticky: assert property (@(posedge clk_sys) disable iff (rst) // see R3
    locked_q |=> locked_q)
    else $error("lock undone");

  // reserved bits never show anything
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst) // see R6
    reg_rdata[4:0] == 5'b0_0000)
    else $error("reserved bits nonzero");

  // status read shows the lock as it stood at the read
  a_status_read: assert property (@(posedge clk_sys) disable iff (rst) // see R5
    (reg_rd && ctrl_hit) |=> reg_rdata[bit_lock_stat] == $past(locked_q))
    else $error("bad status");

  // an accepted start sets the bit and begins programming
  a_start_sets: assert property (@(posedge clk_sys) disable iff (rst) // see R1
    start_ok |=> start_q && state_q == st_prog)
    else $error("start ignored");

  // a stored lock request locks at the end of its store
  a_lock_follows: assert property (@(posedge clk_sys) disable iff (rst) // see R3
    (state_q == st_done && snap_q[cfg_width]) |=> locked_q)
    else $error("lock missed");

  // the lock request lands in the last cell
  a_req_stored: assert property (@(posedge clk_sys) disable iff (rst) // see R7
    (cell_wr && idx_q == last_idx) |=> cells[cfg_width] == $past(snap_q[cfg_width]))
    else $error("req not stored");

  // a locked array never changes again
  a_cells_frozen: assert property (@(posedge clk_sys) disable iff (rst) // see R4
    locked_q |=> $stable(cells))
    else $error("cells changed while locked");

  // busy spans every paced bit plus the finishing cycle
  a_store_length: assert property (@(posedge clk_sys) disable iff (rst) // see R2
    $rose(store_busy) |-> ##store_cycles $fell(store_busy))
    else $error("store length wrong");

  // main scenarios: a finished store, a lock, a refused start, a bare request write
  c_store: cover property (@(posedge clk_sys) disable iff (rst) state_q == st_done);
  c_lock: cover property (@(posedge clk_sys) disable iff (rst) $rose(locked_q));
  c_reject: cover property (@(posedge clk_sys) disable iff (rst) start_req && locked_q);
  c_req_only: cover property (@(posedge clk_sys) disable iff (rst)
    wr_ctrl && reg_wdata[bit_lock_req] && !reg_wdata[bit_start] && !locked_q);
endmodule : nvm_store_lock_control
`default_nettype wire

// [bench/reg_host_model.sv]
// host side model: single register writes and reads with one-cycle strobes
// assumes the bench clock; drives at the falling edge, answer taken one edge later
`timescale 1ns/10ps
`default_nettype none
module reg_host_model (
  input wire logic clk_sys, // system clock
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  output logic [7:0] reg_addr, // register address
  output logic [7:0] reg_wdata, // write data
  input wire logic [7:0] reg_rdata // read data
);
  initial begin // idle bus from time zero
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one write, strobe held across exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wdata = ~d; // released data must not look like the last value
  endtask : wr
  // one read, data registered one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
endmodule : reg_host_model
`default_nettype wire

// [bench/tb_nvm_store_lock_control.sv]
// bench: store/lock control against an integer model of defaults and lock
// assumes 100 MHz clock, short cfg width to keep stores brief
`timescale 1ns/10ps
`default_nettype none
module tb_nvm_store_lock_control;
  import nvm_ctrl_pkg::*;
  localparam int cw = 4; // short store keeps the run brief
  logic clk_sys = 1'b0, rst = 1'b1; // clock and reset
  logic reg_wr, reg_rd, store_busy; // strobes and busy
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd; // register port
  logic [cw-1:0] cfg_bits = '0, cfg_default; // live and stored bits
  logic [15:0] rnd = 16'h9ee3; // random source state
  int errors = 0, checked = 0, cyc = 0, exp_def = 0, lock = 0, req = 0; // counters and model
  initial forever #5 clk_sys = ~clk_sys; // 100 MHz
  always @(posedge clk_sys) begin // hang guard
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      $display("BAD timeout expected done seen hang");
      results();
    end
  end
  reg_host_model i_reg_host_model (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  nvm_store_lock_control #(.cfg_width(cw)) i_nvm_store_lock_control (.clk_sys(clk_sys),
    .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .cfg_bits(cfg_bits), .reg_rdata(reg_rdata), .cfg_default(cfg_default),
    .store_busy(store_busy));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // write the control register with fresh config bits, then let any store finish
  task automatic store(input logic [7:0] v);
    logic go;
    rnd = lfsr(rnd);
    @(negedge clk_sys) cfg_bits = rnd[cw-1:0];
    i_reg_host_model.wr(ctrl_addr, v);
    go = v[bit_start] && lock == 0; // refused once locked
    if (lock == 0) req = int'(v[bit_lock_req]); // request writable until locked
    chk("busy", 8'(go), 8'(store_busy));
    if (go) begin
      i_reg_host_model.rd(ctrl_addr, rd);
      chk("ctrl in store", {1'b1, 1'(req), 6'h00}, rd);
      exp_def = int'(cfg_bits);
      lock = req;
    end
    for (int i = 0; i < 200 && store_busy === 1'b1; i++) @(negedge clk_sys);
    @(negedge clk_sys);
    chk("defaults", 8'(exp_def), 8'(cfg_default));
    i_reg_host_model.rd(ctrl_addr, rd);
    chk("ctrl after", {1'b0, 1'(req), 1'(lock), 5'h00}, rd);
    $display("test store %h done", v);
  endtask : store
  task automatic results();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin // main sequence
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    i_reg_host_model.rd(ctrl_addr, rd);
    chk("ctrl reset", 8'h00, rd);
    i_reg_host_model.rd(8'h10, rd);
    chk("unmapped", 8'h00, rd);
    $display("test reset done");
    store(8'h1f);
    store(8'h00);
    store(8'h80);
    store(8'h80);
    store(8'h40);
    store(8'hc0);
    store(8'h80);
    store(8'hdf);
    results();
  end
endmodule : tb_nvm_store_lock_control
`default_nettype wire
